// [core/cpu_slow_divider.sv]
// Purpose: cpu clock-enable divider for the slowdown mode
// Assumes: ratio is a power-of-two exponent
// Notes:   enable pulses one cycle in every 2**ratio
`include "psave_params.svh"

module cpu_slow_divider #(
	parameter int CNT_W = 7
) (
	input  wire logic            i_sys_clk,
	input  wire logic            i_sys_rst,
	input  wire psave_pkg::ratio_t i_ratio,
	input  wire logic            i_active,
	output logic                 o_cpu_en
);
	import psave_pkg::*;

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] mask;

	// divisor doubles per ratio step, 000 divides by one
	always_comb begin
		mask = CNT_W'((8'h01 << i_ratio) - 8'h01);
		nxt_cnt = i_active ? ((cnt_ff + 1'b1) & mask) : '0;
		o_cpu_en = (cnt_ff == '0);
	end

	// counter runs only while active, held at zero otherwise; peripherals never see it so domains stay aligned
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// [core/module_gate_delay.sv]
// Purpose: delays module-disable bits into per-module clock enables
// Assumes: one instruction cycle equals one cpu enable pulse
// Notes:   absent modules stay disabled whatever software writes
`include "psave_params.svh"

module module_gate_delay #(
	parameter int                N       = 16,
	parameter logic [N-1:0]      PRESENT = '1
) (
	input  wire logic            i_sys_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_instr_tick,
	input  wire logic [N-1:0]    i_disable,
	output logic      [N-1:0]    o_mod_en
);
	logic [N-1:0] en_ff;
	logic [N-1:0] nxt_en;

	// present and not disabled means enabled
	always_comb begin
		nxt_en = i_instr_tick ? (~i_disable & PRESENT) : en_ff;
		o_mod_en = en_ff;
	end

	// change lands one instruction cycle later, set or clear alike
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			en_ff <= PRESENT;
		end else begin
			en_ff <= nxt_en;
		end
	end
endmodule

// [core/power_save_clock_manager.sv]
// Purpose: sleep, idle, cpu slowdown and module clock gating control
// Assumes: core flags the power-save instruction with a one-cycle pulse
// Notes:   clock outputs are enables for clock gates, not clocks
`include "psave_params.svh"

module power_save_clock_manager #(
	parameter int                   N_MOD   = 16,
	parameter logic [N_MOD-1:0]     PRESENT = '1
) (
	input  wire logic               i_sys_clk,
	input  wire logic               i_sys_rst,
	input  wire logic [3:0]         i_addr,
	input  wire logic [15:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [15:0]        o_rdata,
	input  wire logic               i_pwrsave_exec,
	input  wire logic               i_pwrsave_idle,
	input  wire logic               i_irq,
	input  wire logic               i_wdt_timeout,
	input  wire logic               i_wdt_enable,
	input  wire logic               i_fail_safe_clock_monitor_enable,
	input  wire logic [N_MOD-1:0]   i_stop_in_idle,
	output logic                    o_cpu_clk_en,
	output logic                    o_periph_clk_en,
	output logic                    o_sysosc_en,
	output logic                    o_low_power_rc_clock_en,
	output logic                    o_fail_safe_clock_monitor_active,
	output logic                    o_wdt_clear,
	output logic                    o_core_reg_active,
	output logic                    o_flash_reg_active,
	output logic                    o_irq_deliver,
	output logic      [2:0]         o_osc_select,
	output logic      [N_MOD-1:0]   o_mod_clk_en,
	output logic      [N_MOD-1:0]   o_mod_reg_en
);
	import psave_pkg::*;

	// ****************************************
	// state
	// ****************************************
	pwr_state_e       state_ff, nxt_state;
	logic [1:0]       wake_cnt_ff, nxt_wake_cnt;
	logic             irq_hold_ff, nxt_irq_hold;
	logic             roi_ff, nxt_roi;
	logic             slow_en_ff, nxt_slow_en;
	ratio_t           ratio_ff, nxt_ratio;
	logic             vreg_core_ff, nxt_vreg_core;
	logic             vreg_flash_ff, nxt_vreg_flash;
	logic [2:0]       nosc_ff, nxt_nosc;
	logic             lock_ff, nxt_lock;
	logic [2:0]       sleep_osc_ff, nxt_sleep_osc;
	logic [N_MOD-1:0] gate_ff, nxt_gate;
	logic             wclr_ff, nxt_wclr;
	logic [15:0]      rdata_ff, nxt_rdata;
	logic             slow_tick;
	logic             wake_evt;
	logic [N_MOD-1:0] mod_en;

	// ****************************************
	// submodules
	// ****************************************
	cpu_slow_divider #(
		.CNT_W    (7)
	) u_div (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_ratio  (ratio_ff),
		.i_active (slow_en_ff),
		.o_cpu_en (slow_tick)
	);

	// instruction cycle is one cpu enable pulse
	module_gate_delay #(
		.N         (N_MOD),
		.PRESENT   (PRESENT)
	) u_gate (
		.i_sys_clk   (i_sys_clk),
		.i_sys_rst   (i_sys_rst),
		.i_instr_tick(slow_tick | ~slow_en_ff),
		.i_disable   (gate_ff),
		.o_mod_en    (mod_en)
	);

	// wake sources; reset is handled by the synchronous reset path
	assign wake_evt = i_irq | i_wdt_timeout | irq_hold_ff;

	// ****************************************
	// power state machine
	// ****************************************
	// coincident interrupt held until entry completes, then wakes
	always_comb begin
		nxt_state = state_ff;
		nxt_wake_cnt = wake_cnt_ff;
		nxt_irq_hold = 1'b0;
		nxt_wclr = 1'b0;
		nxt_sleep_osc = sleep_osc_ff;
		unique case (state_ff)
			ST_RUN: begin
				if (i_pwrsave_exec) begin
					nxt_state = i_pwrsave_idle ? ST_IDLE : ST_SLEEP;
					nxt_wclr = i_wdt_enable;
					nxt_irq_hold = i_irq;
					nxt_sleep_osc = nosc_ff;
				end
			end
			ST_SLEEP: begin
				if (wake_evt) begin
					nxt_state = ST_WAKE;
					nxt_wake_cnt = `PS_WAKE_CYCLES;
				end
			end
			ST_IDLE: begin
				if (wake_evt) begin
					nxt_state = ST_WAKE;
					nxt_wake_cnt = `PS_WAKE_CYCLES;
				end
			end
			ST_WAKE: begin
				// cpu restarts four cycles after the wake event, after three cycles in wake
				if (wake_cnt_ff == 2'h1) begin
					nxt_state = ST_RUN;
				end
				nxt_wake_cnt = wake_cnt_ff - 2'h1;
			end
		endcase
	end

	// reset returns every control bit to its default
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_ff <= ST_RUN;
			wake_cnt_ff <= 2'h0;
			irq_hold_ff <= 1'b0;
			wclr_ff <= 1'b0;
			sleep_osc_ff <= `PS_RST_NOSC;
		end else begin
			state_ff <= nxt_state;
			wake_cnt_ff <= nxt_wake_cnt;
			irq_hold_ff <= nxt_irq_hold;
			wclr_ff <= nxt_wclr;
			sleep_osc_ff <= nxt_sleep_osc;
		end
	end

	// ****************************************
	// register file
	// ****************************************
	// writes, read capture and hardware clear of slowdown enable
	always_comb begin
		nxt_roi = roi_ff;
		nxt_slow_en = slow_en_ff;
		nxt_ratio = ratio_ff;
		nxt_vreg_core = vreg_core_ff;
		nxt_vreg_flash = vreg_flash_ff;
		nxt_nosc = nosc_ff;
		nxt_lock = lock_ff;
		nxt_gate = gate_ff;
		nxt_rdata = 16'h0000;
		if (i_wr) begin
			unique case (i_addr)
				`PS_ADDR_CLOCK_DIVISOR_REG: begin
					nxt_roi = i_wdata[`PS_BIT_ROI];
					if (!slow_en_ff) begin
						nxt_ratio = i_wdata[`PS_BIT_SLOW_HI:`PS_BIT_SLOW_LO];
					end
					// a set needs the ratio in force, not the one written alongside
					nxt_slow_en = i_wdata[`PS_BIT_SLOWEN] & (ratio_ff != 3'h0);
				end
				`PS_ADDR_RESET_CONTROL_REG: begin
					nxt_vreg_core = i_wdata[`PS_BIT_VREG_CORE];
					nxt_vreg_flash = i_wdata[`PS_BIT_VREG_FLASH];
				end
				`PS_ADDR_OSCILLATOR_CONTROL_REG: begin
					if (!lock_ff) begin
						nxt_nosc = i_wdata[`PS_BIT_NOSC_HI:`PS_BIT_NOSC_LO];
					end
					nxt_lock = lock_ff | i_wdata[`PS_BIT_LOCK];
				end
				`PS_ADDR_GATE: begin
					nxt_gate = i_wdata[N_MOD-1:0];
				end
				default: begin
				end
			endcase
		end
		// hardware clear beats a software write in the same cycle
		if (roi_ff && i_irq) begin
			nxt_slow_en = 1'b0;
		end
		if (i_rd) begin
			unique case (i_addr)
				`PS_ADDR_CLOCK_DIVISOR_REG: nxt_rdata = {roi_ff, ratio_ff, slow_en_ff, 11'h000};
				`PS_ADDR_RESET_CONTROL_REG: nxt_rdata = {4'h0, vreg_flash_ff, 2'h0, vreg_core_ff, 8'h00};
				`PS_ADDR_OSCILLATOR_CONTROL_REG: nxt_rdata = {5'h00, nosc_ff, lock_ff, 7'h00};
				`PS_ADDR_GATE: nxt_rdata = 16'(gate_ff);
				`PS_ADDR_STATUS: nxt_rdata = {14'h0000, state_ff};
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	// register storage
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			roi_ff <= 1'b0;
			slow_en_ff <= 1'b0;
			ratio_ff <= `PS_RST_RATIO;
			vreg_core_ff <= 1'b0;
			vreg_flash_ff <= 1'b0;
			nosc_ff <= `PS_RST_NOSC;
			lock_ff <= 1'b0;
			gate_ff <= '0;
			rdata_ff <= 16'h0000;
		end else begin
			roi_ff <= nxt_roi;
			slow_en_ff <= nxt_slow_en;
			ratio_ff <= nxt_ratio;
			vreg_core_ff <= nxt_vreg_core;
			vreg_flash_ff <= nxt_vreg_flash;
			nosc_ff <= nxt_nosc;
			lock_ff <= nxt_lock;
			gate_ff <= nxt_gate;
			rdata_ff <= nxt_rdata;
		end
	end

	// ****************************************
	// clock enables
	// ****************************************
	// sleep stops every clock but the low-power rc clock kept for the watchdog; idle stops the cpu and the stop-in-idle modules
	always_comb begin
		o_cpu_clk_en = (state_ff == ST_RUN) && (slow_tick || !slow_en_ff);
		o_periph_clk_en = (state_ff != ST_SLEEP);
		o_sysosc_en = (state_ff != ST_SLEEP);
		o_fail_safe_clock_monitor_active = (state_ff != ST_SLEEP) && i_fail_safe_clock_monitor_enable;
		unique case (state_ff)
			ST_SLEEP: o_low_power_rc_clock_en = i_wdt_enable;
			ST_IDLE: o_low_power_rc_clock_en = i_wdt_enable | i_fail_safe_clock_monitor_enable;
			default: o_low_power_rc_clock_en = 1'b1;
		endcase
		o_core_reg_active = (state_ff != ST_SLEEP) || vreg_core_ff;
		o_flash_reg_active = (state_ff != ST_SLEEP) || vreg_flash_ff;
		o_irq_deliver = (state_ff == ST_RUN) && i_irq && !i_pwrsave_exec;
		o_osc_select = (state_ff == ST_RUN) ? nosc_ff : sleep_osc_ff;
		o_wdt_clear = wclr_ff;
		o_rdata = rdata_ff;
		// module off when gated, in sleep, or told to stop in idle
		o_mod_clk_en = mod_en & {N_MOD{o_periph_clk_en}}
			& ~(i_stop_in_idle & {N_MOD{state_ff == ST_IDLE}});
		o_mod_reg_en = mod_en;
	end

	// ****************************************
	// checks
	// ****************************************
	property p_sleep_stop;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_SLEEP) |-> (!o_cpu_clk_en && !o_periph_clk_en && !o_sysosc_en);
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("clocks run in sleep");

	property p_idle_periph;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_IDLE) |-> (!o_cpu_clk_en && o_periph_clk_en);
	endproperty
	a_idle_periph: assert property (p_idle_periph) else $error("idle clocks wrong");

	property p_entry;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_RUN && i_pwrsave_exec && !i_pwrsave_idle) |=> (state_ff == ST_SLEEP);
	endproperty
	a_entry: assert property (p_entry) else $error("sleep not entered");

	property p_wake;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_IDLE && (i_irq || i_wdt_timeout)) |=>
			ST_WAKE == state_ff ##3 state_ff == ST_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("wake timing wrong");

	property p_wdt_clear;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_RUN && i_pwrsave_exec && i_wdt_enable) |=> o_wdt_clear;
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

	property p_ratio_lock;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		slow_en_ff |=> $stable(ratio_ff);
	endproperty
	a_ratio_lock: assert property (p_ratio_lock) else $error("ratio changed while slowed");

	property p_no_zero_slow;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		$rose(slow_en_ff) |-> ($past(ratio_ff) != 3'h0);
	endproperty
	a_no_zero_slow: assert property (p_no_zero_slow) else $error("slowdown at ratio zero");

	property p_roi_clear;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(roi_ff && i_irq) |=> !slow_en_ff;
	endproperty
	a_roi_clear: assert property (p_roi_clear) else $error("slowdown not cleared");

	property p_defer;
		@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state_ff == ST_RUN && i_pwrsave_exec && i_irq) |=> state_ff != ST_RUN ##1 ST_WAKE == state_ff;
	endproperty
	a_defer: assert property (p_defer) else $error("coincident irq lost");
endmodule

// [core/psave_params.svh]
// Purpose: constants for the power-save clock manager
// Assumes: 16-bit register port, 200 MHz system clock
// Notes:   offsets are word addresses on the register port
`ifndef PSAVE_PARAMS_SVH
`define PSAVE_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define PS_ADDR_CLOCK_DIVISOR_REG      4'h0
`define PS_ADDR_RESET_CONTROL_REG        4'h1
`define PS_ADDR_OSCILLATOR_CONTROL_REG      4'h2
`define PS_ADDR_GATE        4'h3
`define PS_ADDR_STATUS      4'h4

// ****************************************
// field positions
// ****************************************
`define PS_BIT_ROI          15
`define PS_BIT_SLOW_HI      14
`define PS_BIT_SLOW_LO      12
`define PS_BIT_SLOWEN       11
`define PS_BIT_VREG_FLASH   11
`define PS_BIT_VREG_CORE    8
`define PS_BIT_NOSC_HI      10
`define PS_BIT_NOSC_LO      8
`define PS_BIT_LOCK         7

// ****************************************
// reset values
// ****************************************
`define PS_RST_RATIO        3'h0
`define PS_RST_NOSC         3'h0

// ****************************************
// timing counts
// ****************************************
`define PS_WAKE_CYCLES      2'h3
`define PS_INSTR_CYCLES     2'h1

`endif

// [core/psave_pkg.sv]
// Purpose: types for the power-save clock manager
// Assumes: nothing
// Notes:   power state machine encodings and the slowdown ratio type
package psave_pkg;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_SLEEP = 2'b01,
		ST_IDLE  = 2'b10,
		ST_WAKE  = 2'b11
	} pwr_state_e;

	typedef logic [2:0] ratio_t;
endpackage

// [verification/core_side_model.sv]
// Purpose: core-side stand-in for the power-save and interrupt lines
// Assumes: called from the bench, all changes by nba at a rising edge
// Notes:   operand line is scrambled once its exec cycle is over
module core_side_model (
	input  wire logic i_sys_clk,
	output logic      o_exec,
	output logic      o_idle,
	output logic      o_irq,
	output logic      o_wdt_to
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet lines from time zero
	initial begin
		o_exec = 1'b0;
		o_idle = 1'b0;
		o_irq = 1'b0;
		o_wdt_to = 1'b0;
	end

	// one-cycle instruction; operand picks the mode
	task automatic save(input logic idle, input logic irq);
		@(posedge i_sys_clk);
		o_exec <= 1'b1;
		o_idle <= idle;
		o_irq <= irq;
	endtask

	// operand is meaningless after exec, so show its inverse
	task automatic save_end();
		@(posedge i_sys_clk);
		o_exec <= 1'b0;
		o_idle <= ~o_idle;
	endtask

	// pending enabled interrupt is a level
	task automatic set_irq(input logic v);
		@(posedge i_sys_clk);
		o_irq <= v;
	endtask

	// watchdog time-out pulse
	task automatic wdt_pulse();
		@(posedge i_sys_clk);
		o_wdt_to <= 1'b1;
		@(posedge i_sys_clk);
		o_wdt_to <= 1'b0;
	endtask
endmodule

// [verification/power_save_clock_manager_tb.sv]
// Purpose: self-checking bench for the power-save clock manager
// Assumes: module 15 absent, ratio 1:1 makes one instruction per cycle
// Notes:   wake and gate delays are waited on under a small bound
`include "psave_params.svh"
module power_save_clock_manager_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import psave_pkg::*;
	localparam logic [15:0] PRES = 16'h7FFF;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        wdt_en;
	logic        fail_safe_clock_monitor_en;
	logic [15:0] stop;
	logic [15:0] rdata, mclk, mreg;
	logic [2:0]  osel;
	logic        exec, idle, irq, wto, cpu_en, per_en, osc_en, low_power_rc_clock;
	logic        fail_safe_clock_monitor_act, wclr, creg, freg, irqd;
	int          failures = 0;
	int          samples_checked = 0;

	always #2.5 sys_clk = ~sys_clk;

	core_side_model core (.i_sys_clk(sys_clk), .o_exec(exec), .o_idle(idle),
		.o_irq(irq), .o_wdt_to(wto));

	power_save_clock_manager #(.N_MOD(16), .PRESENT(PRES)) dut (
		.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
		.i_pwrsave_exec(exec), .i_pwrsave_idle(idle), .i_irq(irq),
		.i_wdt_timeout(wto), .i_wdt_enable(wdt_en), .i_fail_safe_clock_monitor_enable(fail_safe_clock_monitor_en),
		.i_stop_in_idle(stop), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
		.o_sysosc_en(osc_en), .o_low_power_rc_clock_en(low_power_rc_clock), .o_fail_safe_clock_monitor_active(fail_safe_clock_monitor_act),
		.o_wdt_clear(wclr), .o_core_reg_active(creg), .o_flash_reg_active(freg),
		.o_irq_deliver(irqd), .o_osc_select(osel), .o_mod_clk_en(mclk),
		.o_mod_reg_en(mreg));

	// ****
	// tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	// level inputs from the watchdog, clock monitor and per-module idle bits
	task automatic cfg(input logic w, input logic f, input logic [15:0] s);
		wdt_en <= w;
		fail_safe_clock_monitor_en <= f;
		stop <= s;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk);
		wr_s <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	task automatic pulses(input int n, input int e);
		int c;
		c = 0;
		repeat (n) begin
			tick();
			c += int'(cpu_en === 1'b1);
		end
		chk(16'(c), 16'(e));
	endtask

	// bounded wait for the cpu clock to come back; returns cycles taken
	task automatic wait_cpu(output int k);
		k = 0;
		while (cpu_en !== 1'b1 && k < 10) begin
			tick();
			k++;
		end
	endtask

	// ****
	// tests
	// ****
	initial begin
		#50000;
		failures++;
		test_done();
	end

	initial begin
		int k;
		int c;
		cfg(1'b0, 1'b0, 16'h0000);
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk(mclk, PRES);
		chk(16'(cpu_en), 16'h0001);
		rd(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h0000);
		rd(`PS_ADDR_RESET_CONTROL_REG, 16'h0000);
		rd(4'hF, 16'h0000);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h0800);
		rd(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h0000);
		pulses(16, 16);
		// every nonzero ratio code; clearing the enable keeps the old ratio
		for (int r = 1; r < 8; r++) begin
			wr(`PS_ADDR_CLOCK_DIVISOR_REG, {1'b0, 3'(r), 12'h000});
			wr(`PS_ADDR_CLOCK_DIVISOR_REG, {1'b0, 3'(r), 12'h800});
			pulses(128, 128 >> r);
			chk(16'(per_en), 16'h0001);
			wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h0000);
		end
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h3000);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h3800);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h1800);
		rd(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h3800);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'hB800);
		core.set_irq(1'b1);
		#1;
		chk(16'(irqd), 16'h0001);
		rd(`PS_ADDR_CLOCK_DIVISOR_REG, 16'hB000);
		pulses(8, 8);
		core.set_irq(1'b0);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h3800);
		core.set_irq(1'b1);
		rd(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h3800);
		core.set_irq(1'b0);
		wr(`PS_ADDR_CLOCK_DIVISOR_REG, 16'h0000);
		// module gate acts one instruction later, not at once
		wr(`PS_ADDR_GATE, 16'h0001);
		#1;
		chk(16'(mclk[0]), 16'h0001);
		k = 0;
		while (mclk[0] !== 1'b0 && k < 4) begin
			tick();
			k++;
		end
		chk(16'(k), 16'h0001);
		chk(mreg, 16'h7FFE);
		rd(`PS_ADDR_GATE, 16'h0001);
		wr(`PS_ADDR_GATE, 16'h0000);
		repeat (4) tick();
		chk(mclk, PRES);
		// idle with watchdog on and module 1 stopping in idle
		@(posedge sys_clk);
		cfg(1'b1, 1'b0, 16'h0002);
		core.save(1'b1, 1'b0);
		core.save_end();
		#1;
		chk(16'({cpu_en, per_en, osc_en, low_power_rc_clock}), 16'h0007);
		chk(mclk, 16'h7FFD);
		c = 0;
		repeat (3) begin
			c += int'(wclr === 1'b1);
			tick();
		end
		chk(16'(c), 16'h0001);
		rd(`PS_ADDR_STATUS, 16'(ST_IDLE));
		core.save(1'b0, 1'b0);
		core.save_end();
		rd(`PS_ADDR_STATUS, 16'(ST_IDLE));
		core.set_irq(1'b1);
		wait_cpu(k);
		chk(16'(k >= 2 && k <= 5), 16'h0001);
		core.set_irq(1'b0);
		// sleep with regulators to standby, woken by the watchdog
		@(posedge sys_clk);
		cfg(1'b0, 1'b1, 16'h0000);
		wr(`PS_ADDR_OSCILLATOR_CONTROL_REG, 16'h0500);
		#1;
		chk(16'(fail_safe_clock_monitor_act), 16'h0001);
		core.save(1'b0, 1'b0);
		core.save_end();
		#1;
		chk(16'({cpu_en, per_en, osc_en, low_power_rc_clock, fail_safe_clock_monitor_act, creg, freg}), 16'h0000);
		chk(16'(osel), 16'h0005);
		rd(`PS_ADDR_STATUS, 16'(ST_SLEEP));
		core.wdt_pulse();
		wait_cpu(k);
		chk(16'(cpu_en), 16'h0001);
		chk(16'(osel), 16'h0005);
		// sleep with regulators kept, interrupt coincident with the instruction
		@(posedge sys_clk);
		cfg(1'b1, 1'b1, 16'h0000);
		wr(`PS_ADDR_RESET_CONTROL_REG, 16'h0900);
		core.save(1'b0, 1'b1);
		#1;
		chk(16'(irqd), 16'h0000);
		core.save_end();
		#1;
		chk(16'({per_en, low_power_rc_clock, creg, freg}), 16'h0007);
		wait_cpu(k);
		chk(16'(irqd), 16'h0001);
		core.set_irq(1'b0);
		wr(`PS_ADDR_OSCILLATOR_CONTROL_REG, 16'h0380);
		wr(`PS_ADDR_OSCILLATOR_CONTROL_REG, 16'h0600);
		rd(`PS_ADDR_OSCILLATOR_CONTROL_REG, 16'h0380);
		// idle with only the clock monitor on, then reset with a module disabled
		wr(`PS_ADDR_GATE, 16'h0004);
		cfg(1'b0, 1'b1, 16'h0000);
		core.save(1'b1, 1'b0);
		core.save_end();
		#1;
		chk(16'({low_power_rc_clock, fail_safe_clock_monitor_act, wclr}), 16'h0006);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk(mclk, PRES);
		chk(16'(cpu_en), 16'h0001);
		rd(`PS_ADDR_STATUS, 16'(ST_RUN));
		rd(`PS_ADDR_GATE, 16'h0000);
		test_done();
	end
endmodule
